// [logic/rsia_indirect.sv]
// Decoder from a 16-bit file-select pointer to a data or program access.
// Assumes purely combinational use; the caller registers results.
`timescale 1ns/1ps
`include "rsia_regs.svh"

module rsia_indirect (
  // Pointer in
  input wire logic [15:0] file_select_pointer,
  // Decoded access
  output rsia_pkg::rsia_region_type region,
  output logic [11:0] data_addr,
  output logic [14:0] prog_addr,
  output logic self_ref
);

  logic [11:0] lin_off;
  logic [11:0] bank;
  logic [11:0] in_bank;

  // Linear offset split into bank and in-bank position
  assign lin_off = 12'(file_select_pointer - `RSIA_LIN_FIRST);
  assign bank = lin_off / `RSIA_GPR_BLOCK;
  assign in_bank = lin_off % `RSIA_GPR_BLOCK;
  assign prog_addr = file_select_pointer[14:0];

  // Region selection and absolute data address
  always_comb begin
    region = rsia_pkg::rsia_reg_none;
    data_addr = 12'h000;
    if (file_select_pointer[15]) begin
      region = rsia_pkg::rsia_reg_prog;
    end else if (file_select_pointer <= `RSIA_TRAD_LAST) begin
      region = rsia_pkg::rsia_reg_trad;
      data_addr = file_select_pointer[11:0];
    end else if (file_select_pointer >= `RSIA_LIN_FIRST && file_select_pointer <= `RSIA_LIN_LAST) begin
      region = rsia_pkg::rsia_reg_lin;
      data_addr = 12'(bank * `RSIA_BANK_SIZE)
        + 12'(in_bank + 12'(`RSIA_GPR_BASE));
    end
  end

  // Pointer naming an indirect register itself, in any bank
  assign self_ref = (region == rsia_pkg::rsia_reg_trad)
    && (data_addr[6:0] == `RSIA_INDF0_ADDR
      || data_addr[6:0] == `RSIA_INDF1_ADDR);

endmodule : rsia_indirect

// [logic/rsia_pkg.sv]
// Types shared by the return stack and indirect-address block.
// Assumes nothing of its surroundings.
package rsia_pkg;

  // Region that an indirect pointer falls in
  typedef enum logic [1:0] {
    rsia_reg_trad,
    rsia_reg_lin,
    rsia_reg_prog,
    rsia_reg_none
  } rsia_region_type;

  // Stack operation requested by the sequencer
  typedef enum logic [1:0] {
    rsia_op_idle,
    rsia_op_push,
    rsia_op_pop
  } rsia_stack_op_type;

endpackage : rsia_pkg

// [logic/rsia_regs.svh]
// Register offsets, fields, reset values and timing counts for the
// return stack and indirect-address block.
// Assumes APB with 32-bit data, one register per aligned word.
`ifndef RSIA_REGS_SVH
`define RSIA_REGS_SVH

// Register byte offsets
`define RSIA_OFF_CTRL 12'h000
`define RSIA_OFF_PTR 12'h004
`define RSIA_OFF_TOP_ENTRY_LOW 12'h008
`define RSIA_OFF_TOP_ENTRY_HIGH 12'h00c
`define RSIA_OFF_FLAGS 12'h010
`define RSIA_OFF_FSR0 12'h014
`define RSIA_OFF_FSR1 12'h018

// Control fields
`define RSIA_CTRL_FAULT_RST_BIT 0
// Flag fields
`define RSIA_FLAG_OVER_BIT 0
`define RSIA_FLAG_UNDER_BIT 1

// Reset values and full-stack pointer
`define RSIA_PTR_EMPTY 5'h1f
`define RSIA_PTR_TOP 5'h0f
`define RSIA_CTRL_RESET 1'h0
`define RSIA_FSR_RESET 16'h0000

// Address map of the indirect pointer
`define RSIA_TRAD_LAST 16'h0fff
`define RSIA_LIN_FIRST 16'h2000
`define RSIA_LIN_LAST 16'h29af
`define RSIA_GPR_BLOCK 12'h050
`define RSIA_GPR_BASE 7'h20
`define RSIA_BANK_SIZE 12'h080
`define RSIA_INDF0_ADDR 7'h00
`define RSIA_INDF1_ADDR 7'h01

// Timing: extra instruction cycles for a program-memory read
`define RSIA_PROG_EXTRA 2'h1

`endif

// [logic/rsia_stack.sv]
// Sixteen-entry return stack with five-bit pointer.
// Assumes one push or pop per cycle from the sequencer, plus software
// pointer and top-of-stack writes arriving from the register file.
`timescale 1ns/1ps
`include "rsia_regs.svh"

module rsia_stack (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencer side
  input wire logic push,
  input wire logic pop,
  input wire logic [14:0] pc_in,
  input wire logic wrap_mode,
  // Software side
  input wire logic ptr_we,
  input wire logic [4:0] ptr_wdata,
  input wire logic tos_we,
  input wire logic [14:0] tos_wdata,
  // State
  output logic [4:0] ptr_q,
  output logic [14:0] tos,
  output logic over_ev,
  output logic under_ev
);

  logic [14:0] mem_q [0:15];
  logic [4:0] ptr_d;
  logic [4:0] inc;

  // Pointer arithmetic, empty 1f rolls to 00 on push
  assign inc = ptr_q + 5'h01;
  assign over_ev = push && (ptr_q == `RSIA_PTR_TOP);
  assign under_ev = pop && (ptr_q == `RSIA_PTR_EMPTY);
  assign tos = mem_q[ptr_q[3:0]];

  // Next pointer: push increments, pop decrements
  always_comb begin
    ptr_d = ptr_q;
    if (push) begin
      ptr_d = over_ev && wrap_mode ? 5'h00 : inc;
    end else if (pop) begin
      ptr_d = under_ev && wrap_mode ? `RSIA_PTR_TOP : ptr_q - 5'h01;
    end else if (ptr_we) begin
      ptr_d = ptr_wdata;
    end
  end

  // Pointer register, empty at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= `RSIA_PTR_EMPTY;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Entry storage; push writes at the incremented slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 15'h0000;
      end
    end else if (push) begin
      mem_q[ptr_d[3:0]] <= pc_in;
    end else if (tos_we && !pop) begin
      mem_q[ptr_q[3:0]] <= tos_wdata;
    end
  end

endmodule : rsia_stack

// [logic/rsia_top.sv]
// Return stack and indirect-address decoder of a small CPU core.
// Assumes an APB master for software access and a sequencer that
// issues one-cycle push/pop pulses and indirect accesses held until done.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "rsia_regs.svh"

module rsia_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer stack port
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic [14:0] pc_value,
  output logic [14:0] pc_return,
  output logic pc_return_valid,
  output logic stack_fault_reset,
  // Sequencer indirect port
  input wire logic ind_req,
  input wire logic ind_sel,
  input wire logic ind_write,
  input wire logic [7:0] ind_wdata,
  output logic [7:0] ind_rdata,
  output logic ind_done,
  // Data memory port
  output logic [11:0] dmem_addr,
  output logic dmem_we,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  // Program memory port
  output logic [14:0] pmem_addr,
  input wire logic [13:0] pmem_rdata
);

  //////////////////////////////////////////////////////////////////////
  // Declarations

  // Indirect sequencer states
  typedef enum logic [1:0] {
    rsia_st_idle,
    rsia_st_wait,
    rsia_st_done
  } rsia_ind_state_type;

  rsia_ind_state_type ind_q;
  logic fault_rst_en_q;
  logic over_q;
  logic under_q;
  logic [15:0] fsr0_q;
  logic [15:0] fsr1_q;
  logic [4:0] ptr;
  logic [14:0] tos;
  logic over_ev;
  logic under_ev;
  logic wr_acc;
  logic ptr_we;
  logic tos_we;
  logic [14:0] tos_wdata;

  // Decoder results
  logic [15:0] fsr_cur;
  rsia_pkg::rsia_region_type region;
  logic [11:0] data_addr;
  logic [14:0] prog_addr;
  logic self_ref;
  logic [1:0] wait_q;

  // Byte-lane merge used for the pointer pair registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic hi_only);
    merge16 = hi_only ? {wd[7:0], old[7:0]} : wd[15:0];
  endfunction : merge16

  // Write access phase aimed at one register offset
  function automatic logic wr_hit(input logic acc,
                                  input logic [11:0] a,
                                  input logic [11:0] off);
    wr_hit = acc && a == off;
  endfunction : wr_hit

  //////////////////////////////////////////////////////////////////////
  // APB decode, zero-wait

  assign wr_acc = psel && penable && pwrite;
  assign ptr_we = wr_hit(wr_acc, paddr, `RSIA_OFF_PTR);
  assign tos_we = wr_acc
    && (paddr == `RSIA_OFF_TOP_ENTRY_LOW || paddr == `RSIA_OFF_TOP_ENTRY_HIGH);
  assign tos_wdata = paddr == `RSIA_OFF_TOP_ENTRY_HIGH
    ? {pwdata[6:0], tos[7:0]} : {tos[14:8], pwdata[7:0]};

  // Ready and error pulses for each access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > `RSIA_OFF_FSR1;
    end
  end

  // Read data mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `RSIA_OFF_CTRL) begin
        prdata <= {31'h0, fault_rst_en_q};
      end else if (paddr == `RSIA_OFF_PTR) begin
        prdata <= {27'h0, ptr};
      end else if (paddr == `RSIA_OFF_TOP_ENTRY_LOW) begin
        prdata <= {24'h0, tos[7:0]};
      end else if (paddr == `RSIA_OFF_TOP_ENTRY_HIGH) begin
        prdata <= {25'h0, tos[14:8]};
      end else if (paddr == `RSIA_OFF_FLAGS) begin
        prdata <= {30'h0, under_q, over_q};
      end else if (paddr == `RSIA_OFF_FSR0) begin
        prdata <= {16'h0, fsr0_q};
      end else if (paddr == `RSIA_OFF_FSR1) begin
        prdata <= {16'h0, fsr1_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Software registers

  // Fault reset option, wrap mode while clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_rst_en_q <= `RSIA_CTRL_RESET;
    end else if (wr_hit(wr_acc, paddr, `RSIA_OFF_CTRL)) begin
      fault_rst_en_q <= pwdata[`RSIA_CTRL_FAULT_RST_BIT];
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_q <= 1'b0;
      under_q <= 1'b0;
    end else begin
      if (over_ev) begin
        over_q <= 1'b1;
      end else if (wr_acc && paddr == `RSIA_OFF_FLAGS
                   && pwdata[`RSIA_FLAG_OVER_BIT]) begin
        over_q <= 1'b0;
      end
      if (under_ev) begin
        under_q <= 1'b1;
      end else if (wr_acc && paddr == `RSIA_OFF_FLAGS
                   && pwdata[`RSIA_FLAG_UNDER_BIT]) begin
        under_q <= 1'b0;
      end
    end
  end

  // File-select pointers; every write loads all 16 bits from pwdata[15:0]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsr0_q <= `RSIA_FSR_RESET;
      fsr1_q <= `RSIA_FSR_RESET;
    end else begin
      if (wr_hit(wr_acc, paddr, `RSIA_OFF_FSR0)) begin
        fsr0_q <= merge16(fsr0_q, pwdata, 1'b0);
      end
      if (wr_hit(wr_acc, paddr, `RSIA_OFF_FSR1)) begin
        fsr1_q <= merge16(fsr1_q, pwdata, 1'b0);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Return stack

  // PC high latch is not touched here at all
  rsia_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(call_push),
    .pop(ret_pop),
    .pc_in(pc_value),
    .wrap_mode(!fault_rst_en_q),
    .ptr_we(ptr_we),
    .ptr_wdata(pwdata[4:0]),
    .tos_we(tos_we),
    .tos_wdata(tos_wdata),
    .ptr_q(ptr),
    .tos(tos),
    .over_ev(over_ev),
    .under_ev(under_ev)
  );

  //////////////////////////////////////////////////////////////////////
  // Sequencer outputs

  // Pop loads PC from the entry before the decrement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_return <= 15'h0000;
      pc_return_valid <= 1'b0;
    end else begin
      pc_return_valid <= ret_pop;
      if (ret_pop) begin
        pc_return <= tos;
      end
    end
  end

  // Device reset request on fault when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_fault_reset <= 1'b0;
    end else begin
      stack_fault_reset <= fault_rst_en_q && (over_ev || under_ev);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Indirect access

  assign fsr_cur = ind_sel ? fsr1_q : fsr0_q;

  rsia_indirect u_ind (
    .file_select_pointer(fsr_cur),
    .region(region),
    .data_addr(data_addr),
    .prog_addr(prog_addr),
    .self_ref(self_ref)
  );

  //////////////////////////////////////////////////////////////////////
  // Memory ports

  // Memory address and write strobe, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dmem_addr <= 12'h000;
      dmem_we <= 1'b0;
      dmem_wdata <= 8'h00;
      pmem_addr <= 15'h0000;
    end else begin
      dmem_addr <= data_addr;
      pmem_addr <= prog_addr;
      dmem_wdata <= ind_wdata;
      dmem_we <= ind_req && ind_q == rsia_st_idle && ind_write
        && !self_ref
        && region != rsia_pkg::rsia_reg_prog
        && region != rsia_pkg::rsia_reg_none;
    end
  end

  // Access sequencer: data and program writes take two cycles, program reads three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_q <= rsia_st_idle;
      wait_q <= 2'h0;
      ind_done <= 1'b0;
      ind_rdata <= 8'h00;
    end else begin
      ind_done <= 1'b0;
      case (ind_q)
        rsia_st_idle: begin
          // Decode is taken from the pointer of this cycle
          if (ind_req) begin
            ind_q <= rsia_st_wait;
            wait_q <= region == rsia_pkg::rsia_reg_prog && !ind_write
              ? `RSIA_PROG_EXTRA : 2'h0;
          end
        end
        rsia_st_wait: begin
          // Program fetch burns its extra cycle here
          if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
          end else begin
            ind_q <= rsia_st_done;
            ind_done <= 1'b1;
            if (ind_write || self_ref) begin
              ind_rdata <= 8'h00;
            end else if (region == rsia_pkg::rsia_reg_prog) begin
              ind_rdata <= pmem_rdata[7:0];
            end else if (region == rsia_pkg::rsia_reg_none) begin
              ind_rdata <= 8'h00;
            end else begin
              ind_rdata <= dmem_rdata;
            end
          end
        end
        rsia_st_done: begin
          // Rearm only once the request has dropped
          if (!ind_req) begin
            ind_q <= rsia_st_idle;
          end
        end
        default: begin
          ind_q <= rsia_st_idle;
        end
      endcase
    end
  end

endmodule : rsia_top

// [verif/rsia_mem_model.sv]
// Data and program memory on the far side of the indirect port.
// Assumes registered addresses and write strobes from the block.
`timescale 1ns/1ps
module rsia_mem_model (
  // Clock
  input wire logic pclk,
  // Data memory
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  // Program memory
  input wire logic [14:0] pmem_addr,
  output logic [13:0] pmem_rdata
);
  logic [7:0] mem [0:4095];
  // Byte store, written at the clock edge
  always @(posedge pclk) begin
    if (dmem_we) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end
  // Combinational reads; program words follow their address
  assign dmem_rdata = mem[dmem_addr];
  assign pmem_rdata = {pmem_addr[13:8], pmem_addr[7:0] ^ 8'h3c};
endmodule : rsia_mem_model

// [verif/rsia_top_asserts.sv]
// Port checker for the return stack and indirect block.
// Assumes it is bound onto every rsia_top instance.
`timescale 1ns/1ps
module rsia_top_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer and memory
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic pc_return_valid,
  input wire logic stack_fault_reset,
  input wire logic ind_req,
  input wire logic ind_write,
  input wire logic ind_done,
  input wire logic dmem_we
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  property p_apb_ready;
    psel && !penable ##1 psel && penable |-> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready");
  property p_ready_cause;
    pready |-> psel && penable;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  property p_err_range;
    psel && penable && pready && paddr > 12'h018 |-> pslverr;
  endproperty
  a_err_range: assert property (p_err_range) else $error("no slverr");
  property p_pop_valid;
    ret_pop |=> pc_return_valid;
  endproperty
  a_pop_valid: assert property (p_pop_valid) else $error("no pop");
  property p_valid_cause;
    pc_return_valid |-> $past(ret_pop);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("bad pop");
  property p_ind_time;
    $rose(ind_req) |-> ##[2:4] ind_done;
  endproperty
  a_ind_time: assert property (p_ind_time) else $error("ind late");
  property p_we_cause;
    dmem_we |-> ind_req && ind_write;
  endproperty
  a_we_cause: assert property (p_we_cause) else $error("stray we");
  property p_fault_cause;
    stack_fault_reset |-> $past(call_push || ret_pop) ||
      $past(call_push || ret_pop, 2);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("bad fault");
  property p_done_pulse;
    ind_done |=> !ind_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("long done");
endmodule : rsia_top_chk
bind rsia_top rsia_top_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .call_push(call_push), .ret_pop(ret_pop),
  .pc_return_valid(pc_return_valid), .stack_fault_reset(stack_fault_reset),
  .ind_req(ind_req), .ind_write(ind_write), .ind_done(ind_done),
  .dmem_we(dmem_we));

// [verif/testbench.sv]
// Self-checking bench for rsia_top with a memory model.
// Assumes the APB offsets of rsia_regs.svh.
`timescale 1ns/1ps
`include "rsia_regs.svh"
module testbench;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, dmem_addr, wr_addr;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, call_push = 1'b0, ret_pop = 1'b0;
  logic [14:0] pc_value = 15'h0, pc_return, pmem_addr;
  logic pc_return_valid, stack_fault_reset, ind_done, dmem_we;
  logic ind_req = 1'b0, ind_sel = 1'b0, ind_write = 1'b0;
  logic [7:0] ind_wdata = 8'h00, ind_rdata, dmem_wdata, dmem_rdata, b;
  logic [13:0] pmem_rdata;
  int n_errors = 0, checks = 0, n_wr = 0, n_faults = 0, c, base, nw, f;
  typedef struct packed {
    logic [15:0] file_select_pointer;
    logic we;
    logic [11:0] addr;
    logic [7:0] rd;
    logic extra;
  } rsia_tb_row_type;
  rsia_tb_row_type rows [9] = '{'{16'h0025, 1, 12'h025, 0, 0},
    '{16'h0fff, 1, 12'hfff, 0, 0}, '{16'h2000, 1, 12'h020, 0, 0},
    '{16'h204f, 1, 12'h06f, 0, 0}, '{16'h2050, 1, 12'h0a0, 0, 0},
    '{16'h29af, 1, 12'hf6f, 0, 0}, '{16'h0081, 0, 0, 0, 0},
    '{16'h29b0, 0, 0, 0, 0}, '{16'h8123, 0, 0, 8'h1f, 1}};
  // Clock
  always #5 pclk = ~pclk;
  rsia_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .call_push(call_push), .ret_pop(ret_pop), .pc_value(pc_value),
    .pc_return(pc_return), .pc_return_valid(pc_return_valid),
    .stack_fault_reset(stack_fault_reset), .ind_req(ind_req),
    .ind_sel(ind_sel), .ind_write(ind_write), .ind_wdata(ind_wdata),
    .ind_rdata(ind_rdata), .ind_done(ind_done), .dmem_addr(dmem_addr),
    .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
  rsia_mem_model u_mem (.pclk(pclk), .dmem_addr(dmem_addr),
    .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
  // Count data writes and fault pulses
  always @(posedge pclk) begin
    if (dmem_we === 1'b1) begin
      n_wr++;
      wr_addr = dmem_addr;
    end
    if (stack_fault_reset === 1'b1) n_faults++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rdc
  task automatic push(input logic [14:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      call_push <= 1'b1;
      pc_value <= v + 15'(i);
    end
    @(posedge pclk);
    call_push <= 1'b0;
  endtask : push
  task automatic pop();
    @(posedge pclk);
    ret_pop <= 1'b1;
    @(posedge pclk);
    ret_pop <= 1'b0;
    @(posedge pclk);
  endtask : pop
  task automatic popc(input logic [14:0] x);
    pop();
    chk(pc_return_valid, 1'b1);
    chk(pc_return, x);
  endtask : popc
  task automatic ind(input logic s, input logic w, input logic [7:0] d);
    c = 0;
    @(posedge pclk);
    ind_req <= 1'b1;
    ind_sel <= s;
    ind_write <= w;
    ind_wdata <= d;
    do begin
      @(posedge pclk);
      c++;
    end while (ind_done !== 1'b1 && c < 20);
    chk(32'(ind_done), 32'h1);
    b = ind_rdata;
    ind_req <= 1'b0;
  endtask : ind
  task automatic report_and_stop();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, `RSIA_OFF_FSR0 + 12'(4 * i[0]), 32'(rows[i].file_select_pointer));
      nw = n_wr;
      ind(i[0], 1'b1, 8'h40 + 8'(i));
      chk(n_wr - nw, 32'(rows[i].we));
      if (rows[i].we) chk(wr_addr, rows[i].addr);
      ind(i[0], 1'b0, 8'h00);
      chk(b, rows[i].we ? 8'h40 + 8'(i) : rows[i].rd);
      if (i == 0) base = c;
      chk(c, base + 32'(rows[i].extra));
    end
    $display("decode rows done");
    rdc(`RSIA_OFF_PTR, 32'h1f);
    rdc(`RSIA_OFF_CTRL, 32'h0);
    push(15'h2a51, 1);
    rdc(`RSIA_OFF_PTR, 32'h00);
    rdc(`RSIA_OFF_TOP_ENTRY_LOW, 32'h51);
    rdc(`RSIA_OFF_TOP_ENTRY_HIGH, 32'h2a);
    push(15'h0100, 16);
    rdc(`RSIA_OFF_PTR, 32'h00);
    rdc(`RSIA_OFF_FLAGS, 32'h1);
    popc(15'h010f);
    rdc(`RSIA_OFF_PTR, 32'h1f);
    apb(1'b1, `RSIA_OFF_PTR, 32'h0f);
    popc(15'h010e);
    rdc(`RSIA_OFF_PTR, 32'h0e);
    apb(1'b1, `RSIA_OFF_PTR, 32'h1f);
    apb(1'b1, `RSIA_OFF_FLAGS, 32'h3);
    rdc(`RSIA_OFF_FLAGS, 32'h0);
    pop();
    rdc(`RSIA_OFF_FLAGS, 32'h2);
    rdc(`RSIA_OFF_PTR, 32'h0f);
    apb(1'b1, `RSIA_OFF_PTR, 32'h03);
    apb(1'b1, `RSIA_OFF_TOP_ENTRY_LOW, 32'h77);
    apb(1'b1, `RSIA_OFF_TOP_ENTRY_HIGH, 32'h15);
    popc(15'h1577);
    $display("stack done");
    apb(1'b1, `RSIA_OFF_CTRL, 32'h1);
    apb(1'b1, `RSIA_OFF_PTR, 32'h0f);
    f = n_faults;
    push(15'h0001, 1);
    apb(1'b1, `RSIA_OFF_PTR, 32'h1f);
    pop();
    repeat (2) @(posedge pclk);
    chk(n_faults - f, 32'd2);
    apb(1'b0, 12'h01c, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`RSIA_OFF_PTR, 32'h1f);
    rdc(`RSIA_OFF_CTRL, 32'h0);
    $display("fault and reset done");
    report_and_stop();
  end
endmodule : testbench
